// ### core/acml_top.sv
// correctable error status/mask, error control and header log register bank
`timescale 1ns/1ps
module acml_top #(
  parameter int unsigned ADDR_W = acml_pkg::ADDR_W,
  parameter int unsigned HL_WORDS = acml_pkg::HL_WORDS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic warm_rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // correctable events, one-cycle pulses
  input wire logic receiver_error_i,
  input wire logic bad_transaction_packet_i,
  input wire logic bad_link_packet_i,
  input wire logic replay_number_rollover_i,
  input wire logic replay_timer_timeout_i,
  input wire logic advisory_nonfatal_i,
  // uncorrectable event with its index and packet header
  input wire logic ue_event_i,
  input wire logic [4:0] ue_index_i,
  input wire logic [HL_WORDS*32-1:0] ue_header_i,
  // toward the root complex and the transaction layer
  output logic corr_report_o,
  output logic crc_generation_enable_o,
  output logic crc_check_enable_o,
  output logic irq_o
);
  typedef struct packed {
    logic [31:0] ce_status;
    logic [31:0] ce_mask;
    logic [31:0] ue_status;
    logic [4:0] first_error_pointer;
    logic logged;
    logic gen_cap;
    logic gen_en;
    logic chk_cap;
    logic chk_en;
    logic cap_unlock;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic corr_report;
    logic irq;
    logic [31:0] dat;
  } acml_regs_s;

  acml_regs_s st_r;
  acml_regs_s st_nxt;

  logic bus_start;
  logic bus_commit;
  logic [31:0] wmask;
  logic [31:0] wdat;
  logic wr;
  logic [11:0] offs;
  logic [31:0] ce_events;
  logic [31:0] ce_unmasked;
  logic log_locked;
  logic log_capture;
  logic [HL_WORDS*32-1:0] hl_words;
  logic [31:0] ctrl_view;
  logic [31:0] rd_value;

  acml_wb_port u_port (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .ack_o(ack_o),
    .start_o(bus_start),
    .commit_o(bus_commit)
  );

  acml_hdr_log #(
    .WORDS(HL_WORDS)
  ) u_log (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .capture_i(log_capture),
    .hdr_i(ue_header_i),
    .log_o(hl_words)
  );

  // only the low twelve address bits decode; upper bits are don't-care
  assign offs = 12'(adr_i);
  assign wr = bus_commit & we_i;
  assign wmask = acml_pkg::be_mask(sel_i);
  assign wdat = dat_i & wmask;

  always_comb begin
    ce_events = '0;
    ce_events[acml_pkg::CE_RECEIVER] = receiver_error_i;
    ce_events[acml_pkg::CE_BAD_TLP] = bad_transaction_packet_i;
    ce_events[acml_pkg::CE_BAD_LINK] = bad_link_packet_i;
    ce_events[acml_pkg::CE_ROLLOVER] = replay_number_rollover_i;
    ce_events[acml_pkg::CE_TIMEOUT] = replay_timer_timeout_i;
    ce_events[acml_pkg::CE_ADVISORY] = advisory_nonfatal_i;
  end

  // status still records masked events; the report and the correctable interrupt are suppressed
  assign ce_unmasked = ce_events & ~st_r.ce_mask;

  // the log stays frozen while the status bit it points to is still set
  assign log_locked = st_r.logged &
                      st_r.ue_status[st_r.first_error_pointer];
  assign log_capture = ue_event_i & ~log_locked;

  always_comb begin
    ctrl_view = '0;
    ctrl_view[acml_pkg::FEP_W-1:0] = st_r.first_error_pointer;
    ctrl_view[acml_pkg::CTRL_GEN_CAP] = st_r.gen_cap;
    ctrl_view[acml_pkg::CTRL_GEN_EN] = st_r.gen_en;
    ctrl_view[acml_pkg::CTRL_CHK_CAP] = st_r.chk_cap;
    ctrl_view[acml_pkg::CTRL_CHK_EN] = st_r.chk_en;
  end

  // read mux; unmapped offsets answer zero
  always_comb begin
    rd_value = '0;
    unique case (offs)
      acml_pkg::OFS_UE_STATUS: begin
        rd_value = st_r.ue_status;
      end
      acml_pkg::OFS_CE_STATUS: begin
        rd_value = st_r.ce_status & acml_pkg::CE_IMPL;
      end
      acml_pkg::OFS_CE_MASK: begin
        rd_value = st_r.ce_mask & acml_pkg::CE_IMPL;
      end
      acml_pkg::OFS_CTRL: begin
        rd_value = ctrl_view;
      end
      acml_pkg::OFS_HL1: begin
        rd_value = hl_words[31:0];
      end
      acml_pkg::OFS_HL2: begin
        rd_value = hl_words[63:32];
      end
      acml_pkg::OFS_HL3: begin
        rd_value = hl_words[95:64];
      end
      acml_pkg::OFS_HL4: begin
        rd_value = hl_words[127:96];
      end
      acml_pkg::OFS_IRQ_STATUS: begin
        rd_value[acml_pkg::IRQ_W-1:0] = st_r.irq_status;
      end
      acml_pkg::OFS_IRQ_MASK: begin
        rd_value[acml_pkg::IRQ_W-1:0] = st_r.irq_mask;
      end
      acml_pkg::OFS_CAP_UNLOCK: begin
        rd_value[acml_pkg::UNLOCK_BIT] = st_r.cap_unlock;
      end
      default: begin
        rd_value = '0;
      end
    endcase
  end

  always_comb begin
    logic [31:0] ce_clr;
    logic [31:0] ue_clr;
    logic [1:0] irq_clr;
    logic [1:0] irq_set;
    ce_clr = '0;
    ue_clr = '0;
    irq_clr = '0;
    irq_set = '0;
    st_nxt = st_r;

    // read data is latched when the request is first seen and held with ack
    if (bus_start) begin
      st_nxt.dat = we_i ? 32'h0000_0000 : rd_value;
    end

    if (wr && offs == acml_pkg::OFS_CE_STATUS) begin
      ce_clr = wdat & acml_pkg::CE_IMPL;
    end
    if (wr && offs == acml_pkg::OFS_UE_STATUS) begin
      ue_clr = wdat & acml_pkg::UE_IMPL;
    end
    if (wr && offs == acml_pkg::OFS_IRQ_STATUS) begin
      irq_clr = wdat[acml_pkg::IRQ_W-1:0];
    end

    // a new event in the clearing cycle survives the clear
    st_nxt.ce_status = acml_pkg::w1c(st_r.ce_status, ce_clr,
                                     ce_events) & acml_pkg::CE_IMPL;
    st_nxt.ue_status = acml_pkg::w1c(st_r.ue_status, ue_clr,
                                     32'(ue_event_i) << ue_index_i);

    if (wr && offs == acml_pkg::OFS_CE_MASK) begin
      st_nxt.ce_mask = ((st_r.ce_mask & ~wmask) | wdat) &
                       acml_pkg::CE_IMPL;
    end

    if (wr && offs == acml_pkg::OFS_CTRL) begin
      if (sel_i[0]) begin
        st_nxt.gen_en = dat_i[acml_pkg::CTRL_GEN_EN];
        if (st_r.cap_unlock) begin
          st_nxt.gen_cap = dat_i[acml_pkg::CTRL_GEN_CAP];
          st_nxt.chk_cap = dat_i[acml_pkg::CTRL_CHK_CAP];
        end
      end
      if (sel_i[1]) begin
        st_nxt.chk_en = dat_i[acml_pkg::CTRL_CHK_EN];
      end
    end

    if (wr && offs == acml_pkg::OFS_CAP_UNLOCK && sel_i[0]) begin
      st_nxt.cap_unlock = dat_i[acml_pkg::UNLOCK_BIT];
    end
    if (wr && offs == acml_pkg::OFS_IRQ_MASK && sel_i[0]) begin
      st_nxt.irq_mask = dat_i[acml_pkg::IRQ_W-1:0];
    end

    // first reported uncorrectable error freezes the pointer
    if (log_capture) begin
      st_nxt.first_error_pointer = ue_index_i;
      st_nxt.logged = 1'b1;
    end

    st_nxt.corr_report = |ce_unmasked;
    irq_set[acml_pkg::IRQ_CORR] = |ce_unmasked;
    irq_set[acml_pkg::IRQ_UNCORR] = log_capture;
    st_nxt.irq_status = (st_r.irq_status & ~irq_clr) | irq_set;
    st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);

    // warm reset spares the sticky fields and restores the rest
    if (warm_rst_i) begin
      st_nxt.gen_cap = acml_pkg::CAP_RST;
      st_nxt.chk_cap = acml_pkg::CAP_RST;
      st_nxt.cap_unlock = 1'b0;
      st_nxt.irq_status = '0;
      st_nxt.irq_mask = '0;
      st_nxt.irq = 1'b0;
      st_nxt.corr_report = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.ce_status <= acml_pkg::CE_STATUS_RST;
      st_r.ce_mask <= acml_pkg::CE_MASK_RST;
      st_r.gen_cap <= acml_pkg::CAP_RST;
      st_r.chk_cap <= acml_pkg::CAP_RST;
      st_r.gen_en <= acml_pkg::EN_RST;
      st_r.chk_en <= acml_pkg::EN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dat_o = st_r.dat;
  assign corr_report_o = st_r.corr_report;
  assign crc_generation_enable_o = st_r.gen_en;
  assign crc_check_enable_o = st_r.chk_en;
  assign irq_o = st_r.irq;
endmodule // acml_top

// ### core/acml_pkg.sv
// constants, offsets and field layout of the correctable error mask/log bank
package acml_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned HL_WORDS = 4;
  localparam int unsigned FEP_W = 5;
  localparam int unsigned IRQ_W = 2;

  localparam logic [11:0] OFS_UE_STATUS = 12'h104;
  localparam logic [11:0] OFS_CE_STATUS = 12'h110;
  localparam logic [11:0] OFS_CE_MASK = 12'h114;
  localparam logic [11:0] OFS_CTRL = 12'h118;
  localparam logic [11:0] OFS_HL1 = 12'h11c;
  localparam logic [11:0] OFS_HL2 = 12'h120;
  localparam logic [11:0] OFS_HL3 = 12'h124;
  localparam logic [11:0] OFS_HL4 = 12'h128;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h140;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h144;
  localparam logic [11:0] OFS_CAP_UNLOCK = 12'h148;

  localparam int unsigned CE_RECEIVER = 0;
  localparam int unsigned CE_BAD_TLP = 6;
  localparam int unsigned CE_BAD_LINK = 7;
  localparam int unsigned CE_ROLLOVER = 8;
  localparam int unsigned CE_TIMEOUT = 12;
  localparam int unsigned CE_ADVISORY = 13;
  localparam logic [31:0] CE_IMPL = 32'h0000_31c1;
  localparam logic [31:0] CE_STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] CE_MASK_RST = 32'h0000_2000;
  localparam logic [31:0] UE_IMPL = 32'hffff_ffff;

  localparam int unsigned CTRL_GEN_CAP = 5;
  localparam int unsigned CTRL_GEN_EN = 6;
  localparam int unsigned CTRL_CHK_CAP = 7;
  localparam int unsigned CTRL_CHK_EN = 8;
  localparam logic CAP_RST = 1'b1;
  localparam logic EN_RST = 1'b0;

  localparam int unsigned IRQ_CORR = 0;
  localparam int unsigned IRQ_UNCORR = 1;
  localparam int unsigned UNLOCK_BIT = 0;

  // byte enables widened to a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] sel);
    be_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // write-one-to-clear with set winning over clear
  function automatic logic [31:0] w1c(input logic [31:0] cur,
                                      input logic [31:0] clr,
                                      input logic [31:0] set);
    w1c = (cur & ~clr) | set;
  endfunction
endpackage

// ### core/acml_wb_port.sv
// classic wishbone handshake: one-cycle ack and access strobes
`timescale 1ns/1ps
module acml_wb_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  output logic start_o,
  output logic commit_o
);
  typedef struct packed {
    logic ack;
  } acml_port_s;

  acml_port_s st_r;
  acml_port_s st_nxt;

  // start: request seen, data latched; commit: edge at which ack is sampled
  assign start_o = cyc_i & stb_i & ~st_r.ack;
  assign commit_o = cyc_i & stb_i & st_r.ack;
  assign ack_o = st_r.ack;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = start_o;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // acml_wb_port

// ### core/acml_hdr_log.sv
// header log store: four words captured together on the first error
`timescale 1ns/1ps
module acml_hdr_log #(
  parameter int unsigned WORDS = acml_pkg::HL_WORDS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic capture_i,
  input wire logic [WORDS*32-1:0] hdr_i,
  output logic [WORDS*32-1:0] log_o
);
  typedef struct packed {
    logic [WORDS-1:0][31:0] word;
  } acml_log_s;

  acml_log_s st_r;
  acml_log_s st_nxt;

  assign log_o = st_r.word;

  always_comb begin
    st_nxt = st_r;
    if (capture_i) begin
      st_nxt.word = hdr_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // acml_hdr_log

// ### tb/acml_rc_model.sv
// root complex side: counts reports, follows crc enables
`timescale 1ns/1ps
module acml_rc_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic corr_report_i,
  input wire logic gen_en_i,
  input wire logic chk_en_i,
  output int reports_o,
  output logic [1:0] crc_mode_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reports_o <= 0;
    end else if (corr_report_i) begin
      reports_o <= reports_o + 1;
    end
  end
  // link adds and checks crc only while enabled
  assign crc_mode_o = {chk_en_i, gen_en_i};
endmodule // acml_rc_model

// ### tb/acml_top_monitor.sv
// checker for handshake, report and enable timing
`timescale 1ns/1ps
module acml_top_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic warm_rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic receiver_error_i,
  input wire logic bad_transaction_packet_i,
  input wire logic bad_link_packet_i,
  input wire logic replay_number_rollover_i,
  input wire logic replay_timer_timeout_i,
  input wire logic advisory_nonfatal_i,
  input wire logic corr_report_o,
  input wire logic crc_generation_enable_o,
  input wire logic crc_check_enable_o,
  input wire logic irq_o
);
  logic any_ev;
  assign any_ev = receiver_error_i | bad_transaction_packet_i |
    bad_link_packet_i | replay_number_rollover_i |
    replay_timer_timeout_i | advisory_nonfatal_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_write_data: assert property (ack_o && we_i |-> dat_o == 32'h0)
    else $error("data on write ack");
  a_report_cause: assert property (!any_ev |=> !corr_report_o)
    else $error("report without event");
  a_warm_quiet: assert property (warm_rst_i |=> !corr_report_o && !irq_o)
    else $error("report across warm reset");
  a_gen_hold: assert property
    (!(ack_o && we_i) |=> $stable(crc_generation_enable_o))
    else $error("generation enable moved");
  a_chk_hold: assert property
    (!(ack_o && we_i) |=> $stable(crc_check_enable_o))
    else $error("check enable moved");
endmodule // acml_top_monitor

bind acml_top acml_top_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
  .warm_rst_i(warm_rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .dat_o(dat_o), .ack_o(ack_o), .receiver_error_i(receiver_error_i),
  .bad_transaction_packet_i(bad_transaction_packet_i),
  .bad_link_packet_i(bad_link_packet_i),
  .replay_number_rollover_i(replay_number_rollover_i),
  .replay_timer_timeout_i(replay_timer_timeout_i),
  .advisory_nonfatal_i(advisory_nonfatal_i), .corr_report_o(corr_report_o),
  .crc_generation_enable_o(crc_generation_enable_o),
  .crc_check_enable_o(crc_check_enable_o), .irq_o(irq_o));

// ### tb/acml_top_tb.sv
// self-checking bench for the correctable mask and header log bank
`timescale 1ns/1ps
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin \
  mismatches++; $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module acml_top_tb;
  logic clk_i = 0, rst_i = 1, warm_rst_i = 0, cyc_i = 0, stb_i = 0;
  logic we_i = 0, ack_o, ue_event_i = 0, corr_o, gen_o, chk_o, irq_o;
  logic [11:0] adr_i = '0;
  logic [3:0] sel_i = '0;
  logic [31:0] dat_i = '0, dat_o, q;
  logic [5:0] ev = '0;
  logic [4:0] ue_index_i = '0;
  logic [127:0] ue_header_i = '0;
  logic [1:0] crc_mode;
  int mismatches = 0, check_count = 0, reports;
  int bits[6] = '{0, 6, 7, 8, 12, 13};
  always #2.5 clk_i = ~clk_i;
  acml_top DUT (.clk_i(clk_i), .rst_i(rst_i), .warm_rst_i(warm_rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .receiver_error_i(ev[0]), .bad_transaction_packet_i(ev[1]),
    .bad_link_packet_i(ev[2]), .replay_number_rollover_i(ev[3]),
    .replay_timer_timeout_i(ev[4]), .advisory_nonfatal_i(ev[5]),
    .ue_event_i(ue_event_i), .ue_index_i(ue_index_i),
    .ue_header_i(ue_header_i), .corr_report_o(corr_o),
    .crc_generation_enable_o(gen_o), .crc_check_enable_o(chk_o),
    .irq_o(irq_o));
  acml_rc_model u_rc (.clk_i(clk_i), .rst_i(rst_i), .corr_report_i(corr_o),
    .gen_en_i(gen_o), .chk_en_i(chk_o), .reports_o(reports),
    .crc_mode_o(crc_mode));
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    `CHK("ack", 1'b1, ack_o)
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK("reg", e, q)
  endtask
  // event high for one cycle, report judged in the cycle after
  task automatic pulse(input int i, input logic rep);
    ev[i] <= 1'b1;
    @(posedge clk_i);
    ev <= '0;
    @(posedge clk_i);
    `CHK("report", rep, corr_o)
  endtask
  task automatic ue(input logic [4:0] idx, input logic [127:0] h);
    ue_event_i <= 1'b1;
    ue_index_i <= idx;
    ue_header_i <= h;
    @(posedge clk_i);
    ue_event_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic t_reset;
    rdc(12'h114, 32'h0000_2000);
    rdc(12'h118, 32'h0000_00a0);
    rdc(12'h11c, 32'h0);
    rdc(12'h120, 32'h0);
    rdc(12'h124, 32'h0);
    wb(1'b1, 12'h114, 32'hffff_ffff);
    rdc(12'h114, 32'h0000_31c1);
    wb(1'b1, 12'h114, 32'h0);
    rdc(12'h114, 32'h0);
  endtask
  task automatic t_events;
    for (int k = 0; k < 6; k++) begin
      pulse(k, 1'b1);
      rdc(12'h110, 32'h1 << bits[k]);
      wb(1'b1, 12'h110, 32'hffff_ffff);
      rdc(12'h110, 32'h0);
    end
    wb(1'b1, 12'h114, 32'h0000_31c1);
    for (int k = 0; k < 6; k++) pulse(k, 1'b0);
    rdc(12'h110, 32'h0000_31c1);
    `CHK("reports", 6, reports)
  endtask
  task automatic t_ctrl;
    wb(1'b1, 12'h118, 32'hffff_ffff);
    rdc(12'h118, 32'h0000_01e0);
    `CHK("crc", 2'b11, crc_mode)
    wb(1'b1, 12'h118, 32'h0);
    rdc(12'h118, 32'h0000_00a0);
    `CHK("crc", 2'b00, crc_mode)
    wb(1'b1, 12'h148, 32'h1);
    wb(1'b1, 12'h118, 32'h0);
    rdc(12'h118, 32'h0);
    wb(1'b1, 12'h118, 32'h0000_00a0);
    wb(1'b1, 12'h148, 32'h0);
  endtask
  task automatic t_log;
    ue(5'd5, 128'h4444_4444_3333_3333_2222_2222_1111_1111);
    ue(5'd9, 128'h0);
    rdc(12'h118, 32'h0000_00a5);
    rdc(12'h11c, 32'h1111_1111);
    rdc(12'h120, 32'h2222_2222);
    rdc(12'h124, 32'h3333_3333);
    rdc(12'h128, 32'h4444_4444);
    wb(1'b1, 12'h11c, 32'h0);
    rdc(12'h11c, 32'h1111_1111);
    wb(1'b1, 12'h104, 32'h0000_0020);
    ue(5'd9, 128'h8888_8888_7777_7777_6666_6666_5555_5555);
    rdc(12'h118, 32'h0000_00a9);
    rdc(12'h11c, 32'h5555_5555);
  endtask
  task automatic t_irq;
    wb(1'b1, 12'h114, 32'h0);
    wb(1'b1, 12'h140, 32'h3);
    wb(1'b1, 12'h144, 32'h1);
    pulse(0, 1'b1);
    `CHK("irq", 1'b1, irq_o)
    wb(1'b1, 12'h144, 32'h0);
    @(posedge clk_i);
    `CHK("irq", 1'b0, irq_o)
    wb(1'b1, 12'h144, 32'h1);
    @(posedge clk_i);
    `CHK("irq", 1'b1, irq_o)
    wb(1'b1, 12'h140, 32'h1);
    @(posedge clk_i);
    `CHK("irq", 1'b0, irq_o)
    rdc(12'h1f0, 32'h0);
    wb(1'b1, 12'h114, 32'h0000_0041);
    warm_rst_i <= 1'b1;
    @(posedge clk_i);
    warm_rst_i <= 1'b0;
    rdc(12'h114, 32'h0000_0041);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_events();
    t_ctrl();
    t_log();
    t_irq();
    final_report();
  end
  initial begin
    #20000;
    mismatches++;
    final_report();
  end
endmodule // acml_top_tb
